// file: hw/mbac_checker.sv
`include "mbac_defines.svh"
module mbac_checker
	import mbac_pkg::*;
#(
	parameter int HW_SLOTS = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire mbac_mode_type cpuMode,
	input wire logic fwFromSystem,
	input wire logic integrityActive,
	input wire logic codeInEe,
	input wire logic cfgNoRomFromEe,
	input wire logic cfgCopyNoRom,
	input wire logic cfgCopyNoEe,
	input wire logic copyStart,
	input wire mbac_mem_req_type memReq,
	input wire mbac_seg_entry_type segEntry,
	input wire logic [HW_SLOTS-1:0] codeSfrRights,
	input wire mbac_sfr_req_type sfrReq,
	input wire logic [7:0] extRdata,
	output mbac_mem_rsp_type memRsp,
	output logic sfrGrant,
	output logic sfrExc,
	output logic [7:0] sfrRdata,
	output logic [15:0] segTableAddr,
	output mbac_mode_type copyMode
);

	// Own configuration registers
	logic [7:0] segTabLo_r, segTabLo_nxt, segTabHi_r, segTabHi_nxt;
	logic [7:0] fwCtrlLo_r, fwCtrlLo_nxt, fwCtrlHi_r, fwCtrlHi_nxt;
	logic [7:0] xBaseLo_r, xBaseLo_nxt, xBaseHi_r, xBaseHi_nxt;
	logic [7:0] xSizeLo_r, xSizeLo_nxt, xSizeHi_r, xSizeHi_nxt;
	mbac_mode_type copyMode_r, copyMode_nxt;
	// Answer registers
	mbac_mem_rsp_type memRsp_r, memRsp_nxt;
	logic sfrGrant_r, sfrGrant_nxt, sfrExc_r, sfrExc_nxt;
	logic [7:0] sfrRdata_r, sfrRdata_nxt;

	// Memory check intermediates
	mbac_mode_type memMode;
	logic [19:0] physAddr, ramOff;
	logic [16:0] xEnd;
	logic [15:0] xBase;
	logic segHit, segRight, isRd, isWr, isEx, memAllow;
	logic inRom, inTrom, inFwRom, inArom;
	logic inEe, inFwEe, inAee, inSecRow;
	logic inRam, inFwRam, inAram, inXch, inOpRam;
	logic [HW_SLOTS-1:0] fwRights;
	// Register check intermediates
	logic sfrAllow, isCsr, isClksel, isHidden, isKey, isRng;
	logic [$clog2(HW_SLOTS)-1:0] slot;

	assign fwRights = HW_SLOTS'({fwCtrlHi_r, fwCtrlLo_r});
	assign slot = sfrReq.index[$clog2(HW_SLOTS)-1:0];
	assign xBase = {xBaseHi_r, xBaseLo_r};

	// Address translation and region decode
	always_comb begin
		memMode = (memReq.master == MST_COPY) ? copyMode_r : cpuMode;
		isRd = memReq.op == OP_RD;
		isWr = memReq.op == OP_WR;
		isEx = memReq.op == OP_EX;
		// zero table pointer disables every segment
		segHit = ({segTabHi_r, segTabLo_r} != 16'h0000) && segEntry.valid
			&& memReq.addr >= segEntry.first
			&& memReq.addr <= segEntry.last;
		segRight = (isRd & segEntry.rd) | (isWr & segEntry.wr)
			| (isEx & segEntry.ex);
		// only User code is relocated; others see identity
		if (memMode == MODE_USER && memReq.master != MST_COPROC) begin
			physAddr = 20'(memReq.addr + segEntry.reloc);
		end else begin
			physAddr = memReq.addr;
		end
		inRom = physAddr <= `MBAC_ROM_HI;
		inTrom = physAddr <= `MBAC_TROM_HI;
		inFwRom = inTrom && physAddr >= `MBAC_FWROM_LO;
		inArom = inRom && physAddr >= `MBAC_AROM_LO;
		inEe = physAddr >= `MBAC_EE_LO && physAddr <= `MBAC_EE_HI;
		inFwEe = inEe && physAddr <= `MBAC_FWEE_HI;
		inAee = inEe && physAddr >= `MBAC_AEE_LO;
		inSecRow = inEe && physAddr >= `MBAC_SECROW_LO;
		inRam = physAddr >= `MBAC_RAM_LO && physAddr <= `MBAC_RAM_HI;
		inFwRam = inRam && physAddr <= `MBAC_FWRAM_HI;
		inAram = inRam && physAddr >= `MBAC_ARAM_LO;
		inOpRam = physAddr >= `MBAC_OPRAM_LO && physAddr <= `MBAC_OPRAM_HI;
		// Window end kept one bit wider so a full-size window cannot wrap
		ramOff = physAddr - `MBAC_RAM_LO;
		xEnd = {1'b0, xBase} + {1'b0, xSizeHi_r, xSizeLo_r};
		inXch = inAram && ramOff[19:16] == 4'h0
			&& ramOff[15:0] >= xBase
			&& {1'b0, ramOff[15:0]} < xEnd;
	end

	// Memory access decision by mode
	always_comb begin
		memAllow = 1'b0;
		case (memMode)
			MODE_BOOT: begin
				memAllow = (inTrom & ~isWr) | inFwEe | (inFwRam & ~isEx);
			end
			MODE_TEST: begin
				memAllow = (inRom & ~isWr) | inEe | (inRam & ~isEx);
			end
			MODE_FW: begin
				memAllow = inFwRom & ~isWr;
				memAllow = memAllow | (inEe & ~isEx & integrityActive)
					| (inFwEe & fwRights[`MBAC_FW_EE_BIT])
					| (inFwRam & ~isEx);
				memAllow = memAllow | (inXch & ~isEx);
				memAllow = memAllow
					| (inAee & ~isEx & fwFromSystem & integrityActive);
			end
			MODE_SYS: begin
				memAllow = (inArom & ~isWr) | inAee | (inAram & ~isEx);
			end
			MODE_USER: begin
				memAllow = segHit & segRight
					& ((inArom & ~isWr) | inAee | (inAram & ~isEx));
			end
			default: begin
				memAllow = 1'b0;
			end
		endcase
		if ((memMode == MODE_BOOT || memMode == MODE_FW) && inSecRow
				&& isRd) begin
			memAllow = 1'b1;
		end
		// coprocessor reaches only its operand RAM
		if (memReq.master == MST_COPROC) begin
			memAllow = inOpRam & ~isEx;
		end
		// configured read denials, applied last so they always win
		if (memReq.master == MST_CPU && cfgNoRomFromEe && codeInEe
				&& inRom && isRd) begin
			memAllow = 1'b0;
		end
		if (memReq.master == MST_COPY && ((cfgCopyNoRom && inRom)
				|| (cfgCopyNoEe && inEe)) && isRd) begin
			memAllow = 1'b0;
		end
	end

	// Memory answer; a refusal carries no address so nothing is touched
	always_comb begin
		memRsp_nxt = '0;
		if (memReq.valid) begin
			// grant and deny are exclusive, address only on grant
			memRsp_nxt.grant = memAllow;
			memRsp_nxt.deny = ~memAllow;
			memRsp_nxt.physAddr = memAllow ? physAddr : 20'h00000;
		end
	end

	// Copy machine mode latch
	always_comb begin
		copyMode_nxt = copyStart ? cpuMode : copyMode_r;
	end

	// Register access decision by group and mode
	always_comb begin
		isCsr = sfrReq.index == `MBAC_IDX_CSR;
		isHidden = sfrReq.index == `MBAC_IDX_HIDDEN;
		isClksel = sfrReq.index == `MBAC_IDX_CLKSEL;
		isRng = sfrReq.index == `MBAC_IDX_RNG;
		isKey = sfrReq.index >= `MBAC_IDX_KEY_LO
			&& sfrReq.index <= `MBAC_IDX_KEY_HI;
		sfrAllow = 1'b0;
		case (sfrReq.group)
			GRP_SEGCFG: begin
				sfrAllow = cpuMode == MODE_SYS;
			end
			GRP_SYSMGMT: begin
				sfrAllow = cpuMode == MODE_SYS || cpuMode == MODE_BOOT
					|| cpuMode == MODE_TEST;
				// status readable in Firmware and User
				sfrAllow = sfrAllow | (isCsr & ~sfrReq.write
					& (cpuMode == MODE_FW || cpuMode == MODE_USER));
			end
			GRP_FWCFG: begin
				// Firmware may only read the firewall set-up
				sfrAllow = cpuMode == MODE_SYS || cpuMode == MODE_BOOT
					|| cpuMode == MODE_TEST
					|| (cpuMode == MODE_FW && !sfrReq.write);
			end
			GRP_FWOS: begin
				sfrAllow = cpuMode == MODE_BOOT || cpuMode == MODE_TEST
					|| cpuMode == MODE_FW;
			end
			GRP_TEST: begin
				sfrAllow = cpuMode == MODE_TEST;
			end
			GRP_HWCOMP: begin
				case (cpuMode)
					MODE_BOOT, MODE_TEST, MODE_SYS: begin
						sfrAllow = 1'b1;
					end
					MODE_FW: begin
						// firewall rights, clock select always readable
						sfrAllow = fwRights[slot]
							| (isClksel & ~sfrReq.write);
					end
					MODE_USER: begin
						sfrAllow = codeSfrRights[slot];
					end
					default: begin
						sfrAllow = 1'b0;
					end
				endcase
			end
			GRP_CPUGEN: begin
				sfrAllow = 1'b1;
			end
			GRP_CPUBANK: begin
				// banked ones only System and User
				sfrAllow = cpuMode == MODE_SYS || cpuMode == MODE_USER;
			end
			default: begin
				sfrAllow = 1'b0;
			end
		endcase
		if (sfrReq.group == GRP_HWCOMP && isRng && sfrReq.write) begin
			sfrAllow = 1'b0;
		end
	end

	// Register answer and own register updates
	always_comb begin
		segTabLo_nxt = segTabLo_r;
		segTabHi_nxt = segTabHi_r;
		fwCtrlLo_nxt = fwCtrlLo_r;
		fwCtrlHi_nxt = fwCtrlHi_r;
		xBaseLo_nxt = xBaseLo_r;
		xBaseHi_nxt = xBaseHi_r;
		xSizeLo_nxt = xSizeLo_r;
		xSizeHi_nxt = xSizeHi_r;
		sfrGrant_nxt = 1'b0;
		sfrExc_nxt = sfrReq.valid & ~sfrAllow;
		sfrRdata_nxt = 8'h00;
		if (sfrReq.valid && sfrAllow) begin
			sfrGrant_nxt = 1'b1;
			if (sfrReq.write && sfrReq.group == GRP_SEGCFG) begin
				case (sfrReq.index)
					`MBAC_SEG_TAB_LO: segTabLo_nxt = sfrReq.wdata;
					`MBAC_SEG_TAB_HI: segTabHi_nxt = sfrReq.wdata;
					default: begin
					end
				endcase
			end else if (sfrReq.write && sfrReq.group == GRP_FWCFG) begin
				case (sfrReq.index)
					`MBAC_FW_CTRL_LO: fwCtrlLo_nxt = sfrReq.wdata;
					`MBAC_FW_CTRL_HI: fwCtrlHi_nxt = sfrReq.wdata;
					`MBAC_XCH_BASE_LO: xBaseLo_nxt = sfrReq.wdata;
					`MBAC_XCH_BASE_HI: xBaseHi_nxt = sfrReq.wdata;
					`MBAC_XCH_SIZE_LO: xSizeLo_nxt = sfrReq.wdata;
					`MBAC_XCH_SIZE_HI: xSizeHi_nxt = sfrReq.wdata;
					default: begin
					end
				endcase
			end else if (!sfrReq.write) begin
				case (sfrReq.group)
					GRP_SEGCFG: begin
						sfrRdata_nxt = sfrReq.index[0] ? segTabHi_r
							: segTabLo_r;
					end
					GRP_FWCFG: begin
						case (sfrReq.index)
							`MBAC_FW_CTRL_LO: sfrRdata_nxt = fwCtrlLo_r;
							`MBAC_FW_CTRL_HI: sfrRdata_nxt = fwCtrlHi_r;
							`MBAC_XCH_BASE_LO: sfrRdata_nxt = xBaseLo_r;
							`MBAC_XCH_BASE_HI: sfrRdata_nxt = xBaseHi_r;
							`MBAC_XCH_SIZE_LO: sfrRdata_nxt = xSizeLo_r;
							`MBAC_XCH_SIZE_HI: sfrRdata_nxt = xSizeHi_r;
							default: sfrRdata_nxt = 8'h00;
						endcase
					end
					default: begin
						sfrRdata_nxt = extRdata;
					end
				endcase
				if ((sfrReq.group == GRP_SYSMGMT && isHidden)
						|| (sfrReq.group == GRP_HWCOMP && isKey)) begin
					sfrRdata_nxt = 8'h00;
				end
			end
		end
	end

	// All state registers; reset leaves segmentation and firewall closed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			segTabLo_r <= `MBAC_RST_BYTE;
			segTabHi_r <= `MBAC_RST_BYTE;
			fwCtrlLo_r <= `MBAC_RST_BYTE;
			fwCtrlHi_r <= `MBAC_RST_BYTE;
			xBaseLo_r <= `MBAC_RST_BYTE;
			xBaseHi_r <= `MBAC_RST_BYTE;
			xSizeLo_r <= `MBAC_RST_BYTE;
			xSizeHi_r <= `MBAC_RST_BYTE;
			copyMode_r <= MODE_BOOT;
			memRsp_r <= '0;
			sfrGrant_r <= 1'b0;
			sfrExc_r <= 1'b0;
			sfrRdata_r <= `MBAC_RST_BYTE;
		end else begin
			segTabLo_r <= segTabLo_nxt;
			segTabHi_r <= segTabHi_nxt;
			fwCtrlLo_r <= fwCtrlLo_nxt;
			fwCtrlHi_r <= fwCtrlHi_nxt;
			xBaseLo_r <= xBaseLo_nxt;
			xBaseHi_r <= xBaseHi_nxt;
			xSizeLo_r <= xSizeLo_nxt;
			xSizeHi_r <= xSizeHi_nxt;
			copyMode_r <= copyMode_nxt;
			memRsp_r <= memRsp_nxt;
			sfrGrant_r <= sfrGrant_nxt;
			sfrExc_r <= sfrExc_nxt;
			sfrRdata_r <= sfrRdata_nxt;
		end
	end

	// Outputs straight from registers
	assign memRsp = memRsp_r;
	assign sfrGrant = sfrGrant_r;
	assign sfrExc = sfrExc_r;
	assign sfrRdata = sfrRdata_r;
	assign segTableAddr = {segTabHi_r, segTabLo_r};
	assign copyMode = copyMode_r;

endmodule : mbac_checker

// file: hw/mbac_defines.svh
`ifndef MBAC_DEFINES_SVH
`define MBAC_DEFINES_SVH

// Physical memory map, 20-bit byte addresses
`define MBAC_ROM_LO 20'h00000
`define MBAC_ROM_HI 20'h3ffff
`define MBAC_TROM_HI 20'h0ffff
`define MBAC_FWROM_LO 20'h08000
`define MBAC_AROM_LO 20'h10000
`define MBAC_EE_LO 20'h40000
`define MBAC_EE_HI 20'h7ffff
`define MBAC_FWEE_HI 20'h43fff
`define MBAC_AEE_LO 20'h44000
`define MBAC_SECROW_LO 20'h7f000
`define MBAC_RAM_LO 20'h80000
`define MBAC_RAM_HI 20'h83fff
`define MBAC_FWRAM_HI 20'h807ff
`define MBAC_ARAM_LO 20'h80800
`define MBAC_OPRAM_LO 20'h84000
`define MBAC_OPRAM_HI 20'h84fff

// Own register indices inside the segmentation-configuration group
`define MBAC_SEG_TAB_LO 8'h00
`define MBAC_SEG_TAB_HI 8'h01
// Own register indices inside the firewall-configuration group
`define MBAC_FW_CTRL_LO 8'h00
`define MBAC_FW_CTRL_HI 8'h01
`define MBAC_XCH_BASE_LO 8'h02
`define MBAC_XCH_BASE_HI 8'h03
`define MBAC_XCH_SIZE_LO 8'h04
`define MBAC_XCH_SIZE_HI 8'h05
// Special registers by index inside their groups
`define MBAC_IDX_CSR 8'h10
`define MBAC_IDX_HIDDEN 8'h11
`define MBAC_IDX_CLKSEL 8'h20
`define MBAC_IDX_RNG 8'h21
`define MBAC_IDX_KEY_LO 8'h30
`define MBAC_IDX_KEY_HI 8'h3f
// Firewall bit that opens the firmware EEPROM to non-integrity code
`define MBAC_FW_EE_BIT 4'hf

// Reset values
`define MBAC_RST_BYTE 8'h00

`endif

// file: hw/mbac_pkg.sv
package mbac_pkg;

	typedef enum logic [2:0] {
		MODE_BOOT, MODE_TEST, MODE_FW, MODE_SYS, MODE_USER
	} mbac_mode_type;

	typedef enum logic [1:0] {MST_CPU, MST_COPY, MST_COPROC} mbac_master_type;

	typedef enum logic [1:0] {OP_RD, OP_WR, OP_EX} mbac_op_type;

	typedef enum logic [2:0] {
		GRP_SEGCFG, GRP_SYSMGMT, GRP_FWCFG, GRP_FWOS,
		GRP_TEST, GRP_HWCOMP, GRP_CPUGEN, GRP_CPUBANK
	} mbac_group_type;

	typedef struct packed {
		logic valid;
		mbac_master_type master;
		mbac_op_type op;
		logic [19:0] addr;
	} mbac_mem_req_type;

	typedef struct packed {
		logic valid;
		logic rd;
		logic wr;
		logic ex;
		logic [19:0] first;
		logic [19:0] last;
		logic [19:0] reloc;
	} mbac_seg_entry_type;

	typedef struct packed {
		logic valid;
		logic write;
		mbac_group_type group;
		logic [7:0] index;
		logic [7:0] wdata;
	} mbac_sfr_req_type;

	typedef struct packed {
		logic grant;
		logic deny;
		logic [19:0] physAddr;
	} mbac_mem_rsp_type;

endpackage : mbac_pkg

// file: verif/mbac_checker_tb.sv
module mbac_checker_tb
	import mbac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	mbac_mode_type cpuMode = MODE_BOOT;
	mbac_mode_type copyMode;
	logic fwFromSystem = 1'h0, integrityActive = 1'h0, codeInEe = 1'h0;
	logic cfgNoRomFromEe = 1'h0, cfgCopyNoRom = 1'h0, cfgCopyNoEe = 1'h0;
	logic copyStart = 1'h0;
	mbac_seg_entry_type segEntry = '0;
	logic [15:0] codeSfrRights = 16'h0000;
	mbac_mem_req_type memReq;
	mbac_sfr_req_type sfrReq;
	mbac_mem_rsp_type memRsp;
	logic [7:0] extRdata, sfrRdata, lastRd;
	logic sfrGrant, sfrExc;
	logic [15:0] segTableAddr;
	logic [19:0] lastPhys;
	int miscompares = 0, samplesChecked = 0;

	mbac_checker mbac_checker_i (
		.ref_clk, .rst, .cpuMode, .fwFromSystem, .integrityActive,
		.codeInEe, .cfgNoRomFromEe, .cfgCopyNoRom, .cfgCopyNoEe,
		.copyStart, .memReq, .segEntry, .codeSfrRights, .sfrReq,
		.extRdata, .memRsp, .sfrGrant, .sfrExc, .sfrRdata,
		.segTableAddr, .copyMode
	);

	mbac_cpu_model mbac_cpu_model_i (
		.ref_clk, .memReq, .sfrReq, .extRdata, .memRsp, .sfrGrant,
		.sfrExc, .sfrRdata
	);

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	task automatic chk(input string n, input logic [19:0] s, e);
		samplesChecked++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : endOfTest

	// Mode changes land on an edge, ahead of the next request
	task automatic md(input mbac_mode_type v);
		@(posedge ref_clk);
		cpuMode <= v;
	endtask : md

	task automatic m(input mbac_master_type ms, input mbac_op_type o,
		input logic [19:0] a, input logic e);
		mbac_mem_rsp_type r;
		mbac_cpu_model_i.mem(ms, o, a, r);
		lastPhys = r.physAddr;
		chk("memGrant", 20'(r.grant), 20'(e));
		chk("memDeny", 20'(r.deny), 20'(!e));
	endtask : m

	task automatic s(input logic w, input mbac_group_type g,
		input logic [7:0] i, d, input logic e);
		logic gr, ex;
		mbac_cpu_model_i.sfr(w, g, i, d, gr, ex, lastRd);
		chk("sfrGrant", 20'(gr), 20'(e));
		chk("sfrExc", 20'(ex), 20'(!e));
	endtask : s

	// Watchdog: about 60 transfers of 2 cycles need well under 20 us
	initial begin
		#20000;
		miscompares++;
		endOfTest();
	end

	// Mode by mode, then the options, the coprocessor and the copy machine
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		chk("segTableAddr", 20'(segTableAddr), 20'h0);
		md(MODE_USER);
		segEntry <= '{1'h1, 1'h1, 1'h0, 1'h0, 20'h10000, 20'h10fff, 20'h00100};
		codeSfrRights <= 16'h0008;
		m(MST_CPU, OP_RD, 20'h10000, 1'h0);
		md(MODE_BOOT);
		m(MST_CPU, OP_EX, 20'h0ffff, 1'h1);
		m(MST_CPU, OP_RD, 20'h10000, 1'h0);
		m(MST_CPU, OP_WR, 20'h43fff, 1'h1);
		m(MST_CPU, OP_WR, 20'h80800, 1'h0);
		m(MST_CPU, OP_RD, 20'h7f000, 1'h1);
		s(1'h0, GRP_TEST, 8'h00, 8'h00, 1'h0);
		s(1'h1, GRP_FWOS, 8'h00, 8'h11, 1'h1);
		s(1'h0, GRP_CPUBANK, 8'h00, 8'h00, 1'h0);
		s(1'h0, GRP_CPUGEN, 8'h00, 8'h00, 1'h1);
		md(MODE_TEST);
		m(MST_CPU, OP_EX, 20'h3ffff, 1'h1);
		m(MST_CPU, OP_WR, 20'h00000, 1'h0);
		m(MST_CPU, OP_EX, 20'h7ffff, 1'h1);
		m(MST_CPU, OP_WR, 20'h83fff, 1'h1);
		s(1'h0, GRP_TEST, 8'h00, 8'h00, 1'h1);
		s(1'h1, GRP_SEGCFG, 8'h00, 8'h01, 1'h0);
		chk("segTableAddr", 20'(segTableAddr), 20'h0);
		md(MODE_SYS);
		s(1'h1, GRP_SEGCFG, 8'h00, 8'h01, 1'h1);
		chk("segTableAddr", 20'(segTableAddr), 20'h1);
		s(1'h1, GRP_FWCFG, 8'h00, 8'h02, 1'h1);
		s(1'h1, GRP_FWCFG, 8'h03, 8'h08, 1'h1);
		s(1'h1, GRP_FWCFG, 8'h04, 8'h10, 1'h1);
		s(1'h0, GRP_SYSMGMT, 8'h05, 8'h00, 1'h1);
		chk("sfrRdata", 20'(lastRd), 20'h5f);
		s(1'h0, GRP_SYSMGMT, 8'h11, 8'h00, 1'h1);
		chk("sfrRdata", 20'(lastRd), 20'h0);
		s(1'h0, GRP_HWCOMP, 8'h3f, 8'h00, 1'h1);
		chk("sfrRdata", 20'(lastRd), 20'h0);
		s(1'h1, GRP_HWCOMP, 8'h21, 8'h00, 1'h0);
		s(1'h0, GRP_CPUBANK, 8'h00, 8'h00, 1'h1);
		m(MST_CPU, OP_RD, 20'h10000, 1'h1);
		m(MST_CPU, OP_EX, 20'h44000, 1'h1);
		m(MST_CPU, OP_WR, 20'h80800, 1'h1);
		m(MST_CPU, OP_RD, 20'h00000, 1'h0);
		md(MODE_FW);
		m(MST_CPU, OP_EX, 20'h08000, 1'h1);
		m(MST_CPU, OP_RD, 20'h07fff, 1'h0);
		m(MST_CPU, OP_WR, 20'h40000, 1'h0);
		m(MST_CPU, OP_WR, 20'h807ff, 1'h1);
		m(MST_CPU, OP_RD, 20'h7ffff, 1'h1);
		m(MST_CPU, OP_RD, 20'h8080f, 1'h1);
		m(MST_CPU, OP_RD, 20'h80810, 1'h0);
		s(1'h0, GRP_FWCFG, 8'h01, 8'h00, 1'h1);
		s(1'h1, GRP_FWCFG, 8'h01, 8'h80, 1'h0);
		s(1'h1, GRP_FWOS, 8'h01, 8'h00, 1'h1);
		s(1'h0, GRP_HWCOMP, 8'h01, 8'h00, 1'h1);
		s(1'h0, GRP_HWCOMP, 8'h02, 8'h00, 1'h0);
		s(1'h0, GRP_HWCOMP, 8'h20, 8'h00, 1'h1);
		s(1'h0, GRP_SEGCFG, 8'h00, 8'h00, 1'h0);
		md(MODE_FW);
		integrityActive <= 1'h1;
		m(MST_CPU, OP_WR, 20'h40000, 1'h1);
		md(MODE_FW);
		fwFromSystem <= 1'h1;
		m(MST_CPU, OP_WR, 20'h44000, 1'h1);
		integrityActive <= 1'h0;
		m(MST_CPU, OP_WR, 20'h44000, 1'h0);
		md(MODE_SYS);
		integrityActive <= 1'h0;
		fwFromSystem <= 1'h0;
		s(1'h1, GRP_FWCFG, 8'h01, 8'h80, 1'h1);
		md(MODE_FW);
		m(MST_CPU, OP_EX, 20'h40000, 1'h1);
		md(MODE_USER);
		m(MST_CPU, OP_RD, 20'h10000, 1'h1);
		chk("physAddr", lastPhys, 20'h10100);
		m(MST_CPU, OP_WR, 20'h10000, 1'h0);
		m(MST_CPU, OP_RD, 20'h11000, 1'h0);
		s(1'h0, GRP_HWCOMP, 8'h03, 8'h00, 1'h1);
		s(1'h0, GRP_HWCOMP, 8'h04, 8'h00, 1'h0);
		s(1'h0, GRP_SYSMGMT, 8'h10, 8'h00, 1'h1);
		s(1'h1, GRP_SEGCFG, 8'h00, 8'hff, 1'h0);
		chk("segTableAddr", 20'(segTableAddr), 20'h1);
		md(MODE_SYS);
		codeInEe <= 1'h1;
		cfgNoRomFromEe <= 1'h1;
		m(MST_CPU, OP_RD, 20'h10000, 1'h0);
		m(MST_COPROC, OP_WR, 20'h84fff, 1'h1);
		m(MST_CPU, OP_RD, 20'h84000, 1'h0);
		md(MODE_SYS);
		copyStart <= 1'h1;
		@(posedge ref_clk);
		copyStart <= 1'h0;
		cpuMode <= MODE_USER;
		#1 chk("copyMode", 20'(copyMode), 20'(MODE_SYS));
		m(MST_COPY, OP_WR, 20'h80800, 1'h1);
		md(MODE_TEST);
		cfgCopyNoRom <= 1'h1;
		cfgCopyNoEe <= 1'h1;
		m(MST_COPY, OP_RD, 20'h44000, 1'h0);
		m(MST_COPY, OP_RD, 20'h10000, 1'h0);
		// Second reset held two edges so no check sees a half-reset state
		@(posedge ref_clk);
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		#1 chk("segTableAddr", 20'(segTableAddr), 20'h0);
		chk("copyMode", 20'(copyMode), 20'(MODE_BOOT));
		endOfTest();
	end

endmodule : mbac_checker_tb

bind mbac_checker mbac_properties mbac_properties_i (
	.ref_clk, .rst, .cpuMode, .copyStart, .memReq, .sfrReq, .memRsp,
	.sfrGrant, .sfrExc, .sfrRdata, .segTableAddr, .copyMode
);

// file: verif/mbac_cpu_model.sv
module mbac_cpu_model
	import mbac_pkg::*;
(
	input wire logic ref_clk,
	output mbac_mem_req_type memReq,
	output mbac_sfr_req_type sfrReq,
	output logic [7:0] extRdata,
	input wire mbac_mem_rsp_type memRsp,
	input wire logic sfrGrant,
	input wire logic sfrExc,
	input wire logic [7:0] sfrRdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle lines carry junk so a stale value never looks valid
	initial begin
		memReq = '0;
		sfrReq = '0;
		extRdata = 8'hff;
	end

	// Request held until the taking edge, answer read just after it
	task automatic mem(input mbac_master_type m, input mbac_op_type o,
		input logic [19:0] a, output mbac_mem_rsp_type r);
		@(posedge ref_clk);
		memReq <= '{1'h1, m, o, a};
		@(posedge ref_clk);
		memReq.valid <= 1'h0;
		memReq.addr <= ~a;
		#1 r = memRsp;
	endtask : mem

	// Register file data follows the index, so leaks are visible
	task automatic sfr(input logic w, input mbac_group_type g,
		input logic [7:0] i, d, output logic gr, ex,
		output logic [7:0] rd);
		@(posedge ref_clk);
		sfrReq <= '{1'h1, w, g, i, d};
		extRdata <= 8'h5a ^ i;
		@(posedge ref_clk);
		sfrReq.valid <= 1'h0;
		sfrReq.wdata <= ~d;
		extRdata <= ~(8'h5a ^ i);
		#1 gr = sfrGrant;
		ex = sfrExc;
		rd = sfrRdata;
	endtask : sfr

endmodule : mbac_cpu_model

// file: verif/mbac_properties.sv
module mbac_properties
	import mbac_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire mbac_mode_type cpuMode,
	input wire logic copyStart,
	input wire mbac_mem_req_type memReq,
	input wire mbac_sfr_req_type sfrReq,
	input wire mbac_mem_rsp_type memRsp,
	input wire logic sfrGrant,
	input wire logic sfrExc,
	input wire logic [7:0] sfrRdata,
	input wire logic [15:0] segTableAddr,
	input wire mbac_mode_type copyMode
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Helper flags, so that $past only ever sees a plain signal
	logic segWrOk;
	logic bankOk;
	assign segWrOk = sfrReq.valid && sfrReq.write
		&& sfrReq.group == GRP_SEGCFG && cpuMode == MODE_SYS;
	assign bankOk = cpuMode == MODE_SYS || cpuMode == MODE_USER;

	sequence s_seg_acc;
		sfrReq.valid && sfrReq.group == GRP_SEGCFG;
	endsequence

	sequence s_key_rd;
		sfrReq.valid && !sfrReq.write && sfrReq.group == GRP_HWCOMP
			&& sfrReq.index[7:4] == 4'h3;
	endsequence

	// Memory answers come exactly one edge after the request
	a_mem_answer: assert property (
		memReq.valid |=> memRsp.grant ^ memRsp.deny)
		else $error("memory request not answered once");
	a_mem_quiet: assert property (
		!memReq.valid |=> !memRsp.grant && !memRsp.deny)
		else $error("memory answer without request");
	a_deny_noaddr: assert property (
		memRsp.deny |-> memRsp.physAddr == 20'h00000)
		else $error("denied access shows an address");

	// Register answers: grant or exception, never both
	a_sfr_answer: assert property (
		sfrReq.valid |=> sfrGrant ^ sfrExc)
		else $error("register request not answered once");
	a_seg_guard: assert property (
		s_seg_acc ##0 cpuMode != MODE_SYS |=> sfrExc)
		else $error("segment register reached outside System");
	a_seg_hold: assert property (
		$changed(segTableAddr) |-> $past(segWrOk))
		else $error("table pointer changed without System write");
	a_bank_mode: assert property (
		sfrReq.valid && sfrReq.group == GRP_CPUBANK
			|=> sfrGrant == $past(bankOk))
		else $error("banked CPU register access wrong for mode");
	a_key_blank: assert property (
		s_key_rd |=> sfrRdata == 8'h00)
		else $error("key register returned content");

	// The copy machine mode is latched once and then held
	a_copy_latch: assert property (
		copyStart |=> copyMode == $past(cpuMode))
		else $error("copy mode not latched at start");
	a_copy_keep: assert property (
		!copyStart |=> $stable(copyMode))
		else $error("copy mode moved while running");

endmodule : mbac_properties
